/* File: dv/host_bus_model.sv */
module host_bus_model (
  input  wire logic       mclk,      // device clock
  output      logic       reg_wr,    // write strobe
  output      logic       reg_rd,    // read strobe
  output      logic [7:0] reg_addr,  // register offset
  output      logic [7:0] reg_wdata  // write data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one idle cycle after each access keeps every strobe a single pulse
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = wr;
    reg_rd = !wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : access
endmodule : host_bus_model

/* File: dv/testbench.sv */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  load_busy = 1'b0;
  logic                  chk = 1'b0;
  logic                  take, tchk;
  logic [8:0]            engine_select = '0, engine_on = '0, output_on;
  logic [8:0][7:0]       set_duty = '0;
  logic [2:0][7:0]       fader_value = '0;
  logic signed [7:0]     temperature = '0;
  logic [8:0][11:0]      final_duty;
  logic                  reg_wr, reg_rd;
  logic [7:0]            reg_addr, reg_wdata, reg_rdata;
  logic [3:0]            sel = '0;
  logic [11:0]           q[$];
  logic [11:0]           exp_v;
  int                    error_cnt = 0, n_tests = 0, seed = 32'h68c7;
  wire [11:0] obs = (sel == 4'h0) ? {3'h0, output_on} : final_duty[sel - 4'h1];
  always #12.5 mclk = ~mclk;
  host_bus_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  led_output_control uut (.mclk(mclk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .load_busy(load_busy), .engine_select(engine_select),
    .engine_on(engine_on), .set_duty(set_duty), .fader_value(fader_value), .temperature(temperature),
    .output_on(output_on), .final_duty(final_duty));
  // outputs are sampled just after the edge so registered updates have landed
  always @(posedge mclk) begin
    take = reg_rd;
    tchk = chk;
    #1;
    if (take || tchk) begin
      exp_v = q.pop_front();
      `CHK(take ? {4'h0, reg_rdata} : obs, exp_v)
    end
  end
  function automatic logic [11:0] duty(int d, int f, logic [7:0] c, int t);
    int b;
    int s;
    b = c[5] ? (d * d) >>> 4 : d << 4;
    if (c[7:6] != 2'h0) b = (b * f) >>> 8;
    if (c[4:0] != 5'h00) begin
      s = c[4] ? -int'(c[3:0]) : int'(c[3:0]);
      b = b * (10 - (25 - t) * s) / 20;
      b = (b < 0) ? 0 : ((b > 4095) ? 4095 : b);
    end
    return b[11:0];
  endfunction : duty
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    q.push_back({4'h0, e});
    host.access(1'b0, a, 8'h00);
  endtask : rdc
  task automatic outc(input logic [3:0] s, input logic [11:0] e);
    @(negedge mclk);
    sel = s;
    chk = 1'b1;
    q.push_back(e);
    @(negedge mclk);
    chk = 1'b0;
  endtask : outc
  task automatic final_report;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  initial begin
    int i;
    int t;
    logic [7:0] v, c;
    repeat (12) @(negedge mclk);
    arst_n = 1'b1;
    for (i = 4; i < 15; i++) rdc(i[7:0], 8'h00);
    rdc(8'h20, 8'h00);
    host.access(1'b1, 8'h04, 8'hff);
    rdc(8'h04, 8'h01);
    v = 8'($random(seed));
    host.access(1'b1, 8'h05, v);
    rdc(8'h05, v);
    outc(4'h0, {3'h0, 1'b1, v});
    load_busy = 1'b1;
    host.access(1'b1, 8'h05, ~v);
    load_busy = 1'b0;
    rdc(8'h05, v);
    repeat (4) begin
      engine_select = 9'($random(seed));
      engine_on = 9'($random(seed));
      outc(4'h0, {3'h0, (engine_select & engine_on) | (~engine_select & {1'b1, v})});
    end
    engine_select = '0;
    for (i = 0; i < 36; i++) begin
      c = 8'($random(seed));
      c[7:6] = i[1:0];
      c[5] = i[2];
      if (i[4:3] == 2'h0) c[4:0] = 5'h1f;
      if (i[4:3] == 2'h1) c[4:0] = 5'h0f;
      if (i[4:3] == 2'h2) c[4:0] = 5'h00;
      t = (i % 3 == 0) ? 25 : ((i % 3 == 1) ? -10 : $random(seed) % 60);
      temperature = t[7:0];
      set_duty[i % 9] = 8'($random(seed));
      fader_value = 24'($random(seed));
      if (i == 5) fader_value[0] = 8'h00;
      host.access(1'b1, 8'(8'h06 + i % 9), c);
      repeat (12) @(negedge mclk);
      outc(4'(i % 9 + 1), duty(set_duty[i % 9], fader_value[(c[7:6] == 2'h0) ? 2'h0 : 2'(c[7:6] - 2'h1)], c, t));
    end
    final_report();
  end
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule : testbench

/* File: rtl/duty_calc.sv */
module duty_calc (
  duty_calc_if.calc dc  // one channel's settings in, its final duty out
);
  function automatic int slope_tenths(input logic [4:0] code);
    int mag;
    mag = int'(code[3:0]);
    return code[led_ctrl_pkg::SLOPE_SIGN] ? -mag : mag;
  endfunction : slope_tenths

  int base;
  int delta;
  int comp;

  always_comb begin
    if (dc.curve_select) begin
      base = (int'(dc.set_duty) * int'(dc.set_duty)) >>> led_ctrl_pkg::LOG_SHIFT;
    end else begin
      base = int'(dc.set_duty) <<< led_ctrl_pkg::LIN_SHIFT;
    end
    if (dc.fader_map != led_ctrl_pkg::MAP_NONE) begin
      base = (base * int'(dc.fader)) >>> led_ctrl_pkg::FADER_SHIFT;
    end
    delta = (led_ctrl_pkg::REF_TEMP - int'(dc.temperature)) * slope_tenths(dc.comp_slope);
    // scaled by ten so the 0.1 step stays integer; the final halving folds into the divide
    comp  = (base * (led_ctrl_pkg::SLOPE_SCALE - delta)) / (2 * led_ctrl_pkg::SLOPE_SCALE);
    if (dc.comp_slope == led_ctrl_pkg::SLOPE_OFF) begin
      comp = base;
    end
    if (comp < 0) begin
      comp = 0;
    end else if (comp > led_ctrl_pkg::DUTY_MAX) begin
      comp = led_ctrl_pkg::DUTY_MAX;
    end
    dc.final_duty = comp[11:0];
  end
endmodule : duty_calc

/* File: rtl/duty_calc_if.sv */
interface duty_calc_if;
  logic       [7:0]  set_duty;
  logic       [7:0]  fader;
  logic       [1:0]  fader_map;
  logic              curve_select;
  logic       [4:0]  comp_slope;
  logic signed [7:0] temperature;
  logic       [11:0] final_duty;
  modport ctrl (output set_duty, fader, fader_map, curve_select, comp_slope, temperature, input final_duty);
  modport calc (input set_duty, fader, fader_map, curve_select, comp_slope, temperature, output final_duty);
endinterface : duty_calc_if

/* File: rtl/led_ctrl_pkg.sv */
package led_ctrl_pkg;
  localparam int         NUM_OUT        = 9;
  localparam int         DUTY_W         = 12;
  localparam logic [7:0] OFS_ENABLE_HI  = 8'h04;
  localparam logic [7:0] OFS_ENABLE_LO  = 8'h05;
  localparam logic [7:0] OFS_CTRL_FIRST = 8'h06;
  localparam logic [7:0] OFS_CTRL_LAST  = 8'h0e;
  localparam logic [7:0] ENABLE_RST     = 8'h00;
  localparam logic [7:0] CTRL_RST       = 8'h00;
  localparam int         MAP_MSB        = 7;
  localparam int         MAP_LSB        = 6;
  localparam int         CURVE_BIT      = 5;
  localparam int         SLOPE_MSB      = 4;
  localparam int         SLOPE_SIGN     = 4;
  localparam logic [1:0] MAP_NONE       = 2'h0;
  localparam logic [4:0] SLOPE_OFF      = 5'h00;
  localparam int         REF_TEMP       = 25;
  localparam int         SLOPE_SCALE    = 10;
  localparam int         LIN_SHIFT      = 4;
  localparam int         LOG_SHIFT      = 4;
  localparam int         FADER_SHIFT    = 8;
  localparam int         DUTY_MAX       = 4095;
endpackage : led_ctrl_pkg

/* File: rtl/led_output_control.sv */
module led_output_control (
  input  wire logic              mclk,           // 40 MHz device clock
  input  wire logic              arst_n,         // async reset, active low
  input  wire logic              reg_wr,         // register write strobe from serial port
  input  wire logic              reg_rd,         // register read strobe from serial port
  input  wire logic [7:0]        reg_addr,       // register offset
  input  wire logic [7:0]        reg_wdata,      // write data
  output      logic [7:0]        reg_rdata,      // read data, one cycle after reg_rd
  input  wire logic              load_busy,      // engine memory load blocks writes
  input  wire logic [8:0]        engine_select,  // engine owns output i
  input  wire logic [8:0]        engine_on,      // engine's on/off for output i
  input  wire logic [8:0][7:0]   set_duty,       // per-output duty registers
  input  wire logic [2:0][7:0]   fader_value,    // master faders one to three
  input  wire logic signed [7:0] temperature,    // die temperature, degrees
  output      logic [8:0]        output_on,      // current source enables
  output      logic [8:0][11:0]  final_duty      // compensated duty per output
);
  logic       [7:0]      enable_high_ff;
  logic       [7:0]      enable_low_ff;
  logic [8:0][7:0]       ctrl_ff;
  logic [3:0]            scan_ff;
  logic [3:0]            nxt_scan;
  logic [8:0]            output_on_ff;
  logic [8:0][11:0]      final_duty_ff;
  logic [7:0]            reg_rdata_ff;
  logic [7:0]            nxt_rdata;
  logic                  wr_ok;

  duty_calc_if dc_bus ();

  duty_calc u_calc (
    .dc (dc_bus.calc)
  );

  function automatic logic is_ctrl(input logic [7:0] a);
    return (a >= led_ctrl_pkg::OFS_CTRL_FIRST) && (a <= led_ctrl_pkg::OFS_CTRL_LAST);
  endfunction : is_ctrl

  // channel slot of a control offset; only meaningful once is_ctrl holds
  function automatic logic [3:0] ctrl_index(input logic [7:0] a);
    return 4'(a - led_ctrl_pkg::OFS_CTRL_FIRST);
  endfunction : ctrl_index

  assign wr_ok = reg_wr && !load_busy;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      enable_high_ff <= led_ctrl_pkg::ENABLE_RST;
      enable_low_ff  <= led_ctrl_pkg::ENABLE_RST;
    end else if (wr_ok) begin
      if (reg_addr == led_ctrl_pkg::OFS_ENABLE_HI) begin
        enable_high_ff <= {7'h00, reg_wdata[0]};
      end
      if (reg_addr == led_ctrl_pkg::OFS_ENABLE_LO) begin
        enable_low_ff <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= '{default: led_ctrl_pkg::CTRL_RST};
    end else if (wr_ok && is_ctrl(reg_addr)) begin
      ctrl_ff[ctrl_index(reg_addr)] <= reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      output_on_ff <= 9'h000;
    end else begin
      // engine selection wins over the host bits
      output_on_ff <= (engine_select & engine_on) | (~engine_select & {enable_high_ff[0], enable_low_ff});
    end
  end

  // one output per cycle through a shared datapath; each output refreshes every nine cycles
  assign nxt_scan = (scan_ff == 4'(led_ctrl_pkg::NUM_OUT - 1)) ? 4'h0 : scan_ff + 4'h1;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scan_ff <= 4'h0;
    end else begin
      scan_ff <= nxt_scan;
    end
  end

  always_comb begin
    dc_bus.set_duty     = set_duty[scan_ff];
    dc_bus.fader_map    = ctrl_ff[scan_ff][led_ctrl_pkg::MAP_MSB:led_ctrl_pkg::MAP_LSB];
    dc_bus.fader        = (dc_bus.fader_map == led_ctrl_pkg::MAP_NONE) ? 8'h00 : fader_value[dc_bus.fader_map - 2'h1];
    dc_bus.curve_select = ctrl_ff[scan_ff][led_ctrl_pkg::CURVE_BIT];
    dc_bus.comp_slope   = ctrl_ff[scan_ff][led_ctrl_pkg::SLOPE_MSB:0];
    dc_bus.temperature  = temperature;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      final_duty_ff <= '{default: 12'h000};
    end else begin
      final_duty_ff[scan_ff] <= dc_bus.final_duty;
    end
  end

  always_comb begin
    // unmapped offsets read zero so a stray probe sees nothing stale
    nxt_rdata = 8'h00;
    if (reg_addr == led_ctrl_pkg::OFS_ENABLE_HI) begin
      nxt_rdata = enable_high_ff;
    end else if (reg_addr == led_ctrl_pkg::OFS_ENABLE_LO) begin
      nxt_rdata = enable_low_ff;
    end else if (is_ctrl(reg_addr)) begin
      nxt_rdata = ctrl_ff[ctrl_index(reg_addr)];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata  = reg_rdata_ff;
  assign output_on  = output_on_ff;
  assign final_duty = final_duty_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_low_enable_write: assert property (
    wr_ok && reg_addr == led_ctrl_pkg::OFS_ENABLE_LO |=> enable_low_ff == $past(reg_wdata))
    else $error("low enable register did not take the write");

  a_blocked_write: assert property (
    reg_wr && load_busy |=> $stable(enable_low_ff) && $stable(enable_high_ff) && $stable(ctrl_ff))
    else $error("write taken while load was blocking");

  a_upper_unused_zero: assert property (
    enable_high_ff[7:1] == 7'h00)
    else $error("unused enable bits not zero");

  a_engine_override: assert property (
    ##1 output_on == (($past(engine_select) & $past(engine_on))
                      | (~$past(engine_select) & $past({enable_high_ff[0], enable_low_ff}))))
    else $error("output enable does not follow engine selection");

  a_plain_duty: assert property (
    dc_bus.comp_slope == 5'h00 && !dc_bus.curve_select && dc_bus.fader_map == 2'h0
    |=> final_duty[$past(scan_ff)] == {$past(dc_bus.set_duty), 4'h0})
    else $error("uncompensated linear duty wrong");

  a_log_curve: assert property (
    dc_bus.comp_slope == 5'h00 && dc_bus.curve_select && dc_bus.fader_map == 2'h0
    |=> final_duty[$past(scan_ff)] == 12'(({8'h00, $past(dc_bus.set_duty)} * {8'h00, $past(dc_bus.set_duty)}) >> 4))
    else $error("log curve duty wrong");

  a_fader_zero: assert property (
    dc_bus.fader_map != 2'h0 && dc_bus.fader == 8'h00 |=> final_duty[$past(scan_ff)] == 12'h000)
    else $error("zero fader must give zero duty");

  a_ref_temp: assert property (
    temperature == 8'sd25 && dc_bus.comp_slope != 5'h00 && !dc_bus.curve_select && dc_bus.fader_map == 2'h0
    |=> final_duty[$past(scan_ff)] == {1'b0, $past(dc_bus.set_duty), 3'h0})
    else $error("reference temperature must only halve the duty");

  a_scan_visit: assert property (
    scan_ff == 4'h8 |=> scan_ff == 4'h0 ##8 scan_ff == 4'h8)
    else $error("scan does not cycle through nine outputs");

  a_ctrl_write: assert property (
    wr_ok && reg_addr == led_ctrl_pkg::OFS_CTRL_FIRST |=> ctrl_ff[0] == $past(reg_wdata))
    else $error("first control register did not take the write");

  a_high_enable_write: assert property (
    wr_ok && reg_addr == led_ctrl_pkg::OFS_ENABLE_HI |=> enable_high_ff[0] == $past(reg_wdata[0]))
    else $error("upper enable register did not take the write");

  a_write_idle: assert property (
    !reg_wr |=> $stable(enable_low_ff) && $stable(enable_high_ff) && $stable(ctrl_ff))
    else $error("register changed without a write");

  a_read_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_upper_read_zero: assert property (
    reg_rd && reg_addr == led_ctrl_pkg::OFS_ENABLE_HI |=> reg_rdata[7:1] == 7'h00)
    else $error("unused enable bits read back nonzero");

  a_ctrl_readback: assert property (
    reg_rd && reg_addr == led_ctrl_pkg::OFS_CTRL_FIRST |=> reg_rdata == $past(ctrl_ff[0]))
    else $error("first control register read back wrong");

  a_fader_one: assert property (
    dc_bus.fader_map == 2'h1 |-> dc_bus.fader == fader_value[0])
    else $error("map code one does not pick fader one");

  a_fader_two: assert property (
    dc_bus.fader_map == 2'h2 |-> dc_bus.fader == fader_value[1])
    else $error("map code two does not pick fader two");

  a_fader_three: assert property (
    dc_bus.fader_map == 2'h3 |-> dc_bus.fader == fader_value[2])
    else $error("map code three does not pick fader three");

  a_engine_owns: assert property (
    engine_select[8] |=> output_on[8] == $past(engine_on[8]))
    else $error("engine-owned ninth output ignores the engine");

  // below the reference point a positive slope can only pull the duty under half, a negative one over it
  a_slope_positive: assert property (
    temperature < 8'sd25 && dc_bus.comp_slope[4] == 1'b0 && dc_bus.comp_slope != 5'h00
    && !dc_bus.curve_select && dc_bus.fader_map == 2'h0
    |=> {1'b0, $past(dc_bus.set_duty), 3'h0} >= final_duty[$past(scan_ff)])
    else $error("positive slope raised the cold duty");

  a_slope_negative: assert property (
    temperature < 8'sd25 && dc_bus.comp_slope[4] == 1'b1
    && !dc_bus.curve_select && dc_bus.fader_map == 2'h0
    |=> final_duty[$past(scan_ff)] >= {1'b0, $past(dc_bus.set_duty), 3'h0})
    else $error("negative slope lowered the cold duty");

  a_scan_bound: assert property (
    4'h8 >= scan_ff)
    else $error("scan index left the nine outputs");
endmodule : led_output_control
